// [core/video_sync_pkg.sv]
// Timing constants and carrier types for the bit-mapped video sync controller
package video_sync_pkg;
	localparam int unsigned FIELDS_PER_SEC  = 60;
	localparam int unsigned LINES_PER_FIELD = 262;
	localparam int unsigned CYCLES_PER_LINE = 14;
	localparam int unsigned BITS_PER_BYTE   = 8;
	localparam int unsigned NOMINAL_CLOCK_HZ = FIELDS_PER_SEC * LINES_PER_FIELD
		* CYCLES_PER_LINE * BITS_PER_BYTE;

	localparam logic [3:0] CYCLE_LAST      = 4'hD;
	localparam logic [3:0] CYCLE_SKIP_LAST = 4'hC;
	localparam logic [8:0] LINE_LAST       = 9'h105;

	localparam logic [8:0] VSYNC_LINES  = 9'h006;
	localparam logic [8:0] INT_LINE     = 9'h03E;
	localparam logic [8:0] WINDOW_FIRST = 9'h040;
	localparam logic [8:0] WINDOW_LINES = 9'h080;
	localparam logic [8:0] WINDOW_LAST  = 9'h0BF;
	localparam logic [8:0] FLAG_LINES   = 9'h004;

	localparam logic [3:0] DMA_FIRST_CYCLE = 4'h2;
	localparam logic [3:0] DMA_LAST_CYCLE  = 4'h9;
	localparam logic [3:0] SYNC_END_CYCLE  = 4'h1;

	localparam logic [7:0] SHIFT_RESET = 8'h00;

	typedef struct packed {
		logic first;
		logic second;
		logic code_hi;
		logic code_lo;
	} cpu_timing_t;

	typedef struct packed {
		logic sync_n;
		logic video;
	} video_out_t;
endpackage : video_sync_pkg

// [core/reset_conditioner.sv]
// Reset conditioner driving a cleaned system clear output
`timescale 1ns/10ps
`default_nettype none
module reset_conditioner
	import video_sync_pkg::*;
(
	input  wire logic i_clock,
	input  wire logic i_arst_n,
	output logic      o_clear_n
);
	logic stage_reg;
	logic clear_reg;

	// Asserts at once, releases after two clean edges
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			stage_reg <= 1'b0;
			clear_reg <= 1'b0;
		end else begin
			stage_reg <= 1'b1;
			clear_reg <= stage_reg;
		end
	end

	assign o_clear_n = clear_reg;

	chk_clear_follows: assert property (@(posedge i_clock)
		!i_arst_n |-> ##1 !o_clear_n)
		else $error("clear output did not follow reset");
endmodule : reset_conditioner
`default_nettype wire

// [core/video_sync_dma.sv]
// Bit-mapped video sync, interrupt, status flag and DMA request controller
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Timing assumes clock of 60 fields x 262 lines x 14 cycles x 8 bits.
// - Field length is 262 counted horizontal lines, non-interlaced.
// - Composite sync derives from the two timing pulses plus state codes via line skip.
// - Interrupt low once per field, 56 lines after vertical sync ends.
// - Status flag low four lines before window and last four inside.
// - Each window line requests DMA from third cycle for eight cycles.
// - With state code 01, each second pulse loads a byte, sent MSB first.
// - On/off strobes set and clear display flip-flop gating DMA, interrupt.
// - Window is 128 of 262 lines; no DMA or video outside.
// - Supports 64 by 128 matrix; vertical resolution set by software.
// - Reset input initialises the whole device while asserted.
// - Clear output carries a conditioned copy of reset.
// - Composite sync and luminance leave as separate outputs.
// - Hsync starts after second pulse of first cycle, ends two cycles on.
// - Vertical sync starts with line 262 sync, lasts six lines.
// - State code other than 10 during hsync shortens line by one cycle.
// - Shift register moves MSB first, zero fills LSB each shift.
module video_sync_dma
	import video_sync_pkg::*;
(
	input  wire logic       i_clock,
	input  wire logic       i_arst_n,
	input  wire logic       i_timing_pulse_first,
	input  wire logic       i_timing_pulse_second,
	input  wire logic       i_state_code_hi,
	input  wire logic       i_state_code_lo,
	input  wire logic       i_display_on_strobe,
	input  wire logic       i_display_off_strobe,
	input  wire logic [7:0] i_data_bus,
	output logic            o_comp_sync_n,
	output logic            o_video,
	output logic            o_dma_out_request_n,
	output logic            o_interrupt_n,
	output logic            o_display_status_flag_n,
	output logic            o_clear_n
);
	typedef enum logic [1:0] {
		SYNC_IDLE,
		SYNC_WAIT_SECOND,
		SYNC_ACTIVE
	} sync_state_t;

	cpu_timing_t  timing;
	video_out_t   vid;
	sync_state_t  sync_reg;
	sync_state_t  sync_next;
	logic [3:0]   cycle_reg;
	logic [3:0]   cycle_next;
	logic [8:0]   line_reg;
	logic [8:0]   line_next;
	logic [1:0]   end_count_reg;
	logic         skip_reg;
	logic         display_reg;
	logic [7:0]   shift_reg;
	logic [2:0]   bit_count_reg;
	logic         dma_reg;
	logic         int_reg;
	logic         flag_reg;
	logic         vsync_reg;

	wire logic [3:0] cycle_end;
	wire logic       line_done;
	wire logic       in_window;
	wire logic       dma_cycle;
	wire logic       load_byte;
	wire logic       code_ok;
	wire logic       flag_line;

	assign timing = '{first: i_timing_pulse_first,
		second: i_timing_pulse_second,
		code_hi: i_state_code_hi, code_lo: i_state_code_lo};

	// Decodes a line number against a window of given start and length
	function automatic logic line_in(input logic [8:0] line,
		input logic [8:0] start, input logic [8:0] len);
		line_in = (line >= start) && (line < 9'(start + len));
	endfunction : line_in

	reset_conditioner u_reset (
		.i_clock  (i_clock),
		.i_arst_n (i_arst_n),
		.o_clear_n(o_clear_n)
	);

	assign code_ok   = timing.code_hi && !timing.code_lo;
	assign cycle_end = skip_reg ? CYCLE_SKIP_LAST : CYCLE_LAST;
	assign line_done = timing.first && (cycle_reg == cycle_end);
	assign in_window = line_in(line_reg, WINDOW_FIRST, WINDOW_LINES);
	assign dma_cycle = in_window && display_reg
		&& (cycle_reg >= DMA_FIRST_CYCLE)
		&& (cycle_reg <= DMA_LAST_CYCLE);
	assign load_byte = timing.second && !timing.code_hi && timing.code_lo
		&& display_reg && in_window;
	assign flag_line = line_in(line_reg, 9'(WINDOW_FIRST - FLAG_LINES),
			FLAG_LINES)
		|| line_in(line_reg, 9'(WINDOW_LAST - FLAG_LINES + 9'h001),
			FLAG_LINES);

	// Machine cycles counted on the first timing pulse
	always_comb begin
		cycle_next = cycle_reg;
		line_next  = line_reg;
		if (timing.first) begin
			if (cycle_reg == cycle_end) begin
				cycle_next = 4'h0;
				line_next  = (line_reg == LINE_LAST) ? 9'h000
					: 9'(line_reg + 9'h001);
			end else begin
				cycle_next = 4'(cycle_reg + 4'h1);
			end
		end
	end

	// Horizontal sync sequencing from the two pulses and the skip-adjusted line end
	always_comb begin
		sync_next = sync_reg;
		case (sync_reg)
			SYNC_IDLE: begin
				if (line_done)
					sync_next = SYNC_WAIT_SECOND;
			end
			SYNC_WAIT_SECOND: begin
				if (timing.second)
					sync_next = SYNC_ACTIVE;
			end
			SYNC_ACTIVE: begin
				if (timing.first && end_count_reg == 2'h1)
					sync_next = SYNC_IDLE;
			end
			default: sync_next = SYNC_IDLE;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cycle_reg <= 4'h0;
			line_reg  <= 9'h000;
			sync_reg  <= SYNC_IDLE;
		end else begin
			cycle_reg <= cycle_next;
			line_reg  <= line_next;
			sync_reg  <= sync_next;
		end
	end

	// Counts first pulses while sync is active; samples codes for skip
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			end_count_reg <= 2'h0;
			skip_reg      <= 1'b0;
		end else begin
			if (sync_reg != SYNC_ACTIVE)
				end_count_reg <= 2'h0;
			else if (timing.first)
				end_count_reg <= 2'(end_count_reg + 2'h1);
			if (sync_reg == SYNC_ACTIVE && timing.first)
				skip_reg <= !code_ok;
			else if (line_done)
				skip_reg <= 1'b0;
		end
	end

	// Vertical sync from line 262 rollover for six lines
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n)
			vsync_reg <= 1'b0;
		else if (sync_next == SYNC_ACTIVE && sync_reg != SYNC_ACTIVE)
			vsync_reg <= (line_reg < VSYNC_LINES);
	end

	// Display enable flip-flop; on strobe wins
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n)
			display_reg <= 1'b0;
		else if (i_display_on_strobe)
			display_reg <= 1'b1;
		else if (i_display_off_strobe)
			display_reg <= 1'b0;
	end

	// Registered control outputs
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			dma_reg  <= 1'b0;
			int_reg  <= 1'b0;
			flag_reg <= 1'b0;
		end else begin
			dma_reg  <= dma_cycle;
			int_reg  <= display_reg && (line_reg == INT_LINE);
			flag_reg <= flag_line;
		end
	end

	// Shifter: one byte per machine cycle, zero fill
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			shift_reg     <= SHIFT_RESET;
			bit_count_reg <= 3'h0;
		end else if (load_byte) begin
			shift_reg     <= i_data_bus;
			bit_count_reg <= 3'h0;
		end else begin
			shift_reg     <= {shift_reg[6:0], 1'b0};
			bit_count_reg <= 3'(bit_count_reg + 3'h1);
		end
	end

	assign vid.sync_n = !((sync_reg == SYNC_ACTIVE) ^ vsync_reg);
	assign vid.video  = shift_reg[7];
	assign o_comp_sync_n           = vid.sync_n;
	assign o_video                 = vid.video;
	assign o_dma_out_request_n     = !dma_reg;
	assign o_interrupt_n           = !int_reg;
	assign o_display_status_flag_n = !flag_reg;

	// Counter and sync sequencing
	chk_field_wrap: assert property (@(posedge i_clock)
		disable iff (!i_arst_n)
		line_reg <= LINE_LAST)
		else $error("line counter past field end");
	chk_line_rollover: assert property (@(posedge i_clock)
		disable iff (!i_arst_n)
		line_done && line_reg == LINE_LAST |=> line_reg == 9'h000)
		else $error("line counter did not roll over");
	chk_cycle_range: assert property (@(posedge i_clock)
		disable iff (!i_arst_n)
		cycle_reg <= CYCLE_LAST)
		else $error("cycle counter out of range");
	chk_sync_start: assert property (@(posedge i_clock)
		disable iff (!i_arst_n)
		sync_reg == SYNC_WAIT_SECOND && timing.second
		|=> sync_reg == SYNC_ACTIVE)
		else $error("hsync did not start");
	chk_sync_end: assert property (@(posedge i_clock)
		disable iff (!i_arst_n)
		sync_reg == SYNC_ACTIVE && timing.first && end_count_reg == 2'h1
		|=> sync_reg == SYNC_IDLE)
		else $error("hsync did not end");
	chk_skip_sample: assert property (@(posedge i_clock)
		disable iff (!i_arst_n)
		sync_reg == SYNC_ACTIVE && timing.first && !code_ok |=> skip_reg)
		else $error("bad state code did not shorten line");
	chk_vsync_start: assert property (@(posedge i_clock)
		disable iff (!i_arst_n)
		sync_next == SYNC_ACTIVE && sync_reg != SYNC_ACTIVE
		&& line_reg == 9'h000 |=> vsync_reg)
		else $error("vsync did not start with field");
	chk_vsync_end: assert property (@(posedge i_clock)
		disable iff (!i_arst_n)
		sync_reg == SYNC_ACTIVE && line_reg == VSYNC_LINES |-> !vsync_reg)
		else $error("vsync longer than six lines");

	// Requests, interrupt and status flag
	chk_dma_window: assert property (@(posedge i_clock)
		disable iff (!i_arst_n)
		!o_dma_out_request_n |-> $past(in_window) && $past(display_reg))
		else $error("dma request outside window");
	chk_dma_start: assert property (@(posedge i_clock)
		disable iff (!i_arst_n)
		$fell(o_dma_out_request_n) |-> $past(cycle_reg) == DMA_FIRST_CYCLE)
		else $error("dma request began in wrong cycle");
	chk_dma_stop: assert property (@(posedge i_clock)
		disable iff (!i_arst_n)
		$rose(o_dma_out_request_n)
		|-> $past(cycle_reg) == 4'(DMA_LAST_CYCLE + 4'h1) || !$past(display_reg))
		else $error("dma request ended in wrong cycle");
	chk_dma_gate: assert property (@(posedge i_clock)
		disable iff (!i_arst_n)
		!display_reg |=> o_dma_out_request_n)
		else $error("dma request while display off");
	chk_int_gate: assert property (@(posedge i_clock)
		disable iff (!i_arst_n)
		!o_interrupt_n |-> $past(line_reg) == INT_LINE && $past(display_reg))
		else $error("interrupt at wrong line or while disabled");
	chk_int_off: assert property (@(posedge i_clock)
		disable iff (!i_arst_n)
		!display_reg |=> o_interrupt_n)
		else $error("interrupt while display off");
	chk_display_off: assert property (@(posedge i_clock)
		disable iff (!i_arst_n)
		i_display_off_strobe && !i_display_on_strobe |=> !display_reg)
		else $error("display did not turn off");
	chk_flag_lines: assert property (@(posedge i_clock)
		disable iff (!i_arst_n)
		!o_display_status_flag_n |-> $past(flag_line))
		else $error("status flag at wrong line");

	// Luminance shifter
	chk_load_byte: assert property (@(posedge i_clock)
		disable iff (!i_arst_n)
		load_byte |=> shift_reg == $past(i_data_bus))
		else $error("byte not captured");
	chk_zero_fill: assert property (@(posedge i_clock)
		disable iff (!i_arst_n)
		!load_byte |=> shift_reg[0] == 1'b0)
		else $error("shift did not zero fill");
	chk_shift_empty: assert property (@(posedge i_clock)
		disable iff (!i_arst_n)
		bit_count_reg == 3'h7 && !load_byte |=> shift_reg == SHIFT_RESET)
		else $error("shifter not empty after eight bits");
endmodule : video_sync_dma
`default_nettype wire

// [verif/cpu_timing_model.sv]
// Processor-side model: machine-cycle pulses, state codes and DMA bytes
`timescale 1ns/10ps
`default_nettype none
module cpu_timing_model
	import video_sync_pkg::*;
(
	input  wire logic       i_clock,
	input  wire logic       i_arst_n,
	input  wire logic       i_bad_code,
	input  wire logic       i_dma_request_n,
	output var cpu_timing_t o_timing,
	output var logic [7:0]  o_data
);
	logic [2:0] phase_reg;
	logic [7:0] byte_reg;
	logic       cycle_end;

	// Codes change before the next first pulse and hold through the second
	assign cycle_end = (phase_reg == 3'h6);

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			phase_reg <= 3'h0;
			byte_reg  <= 8'h5A;
			o_timing  <= 4'h2;
			o_data    <= 8'hA5;
		end else begin
			phase_reg       <= phase_reg + 3'h1;
			o_timing.first  <= (phase_reg == 3'h7);
			o_timing.second <= (phase_reg == 3'h4);
			if (cycle_end && !i_dma_request_n) begin
				o_timing.code_hi <= 1'b0;
				o_timing.code_lo <= 1'b1;
				o_data           <= byte_reg;
				byte_reg         <= byte_reg + 8'h3B;
			end else if (cycle_end) begin
				o_timing.code_hi <= !i_bad_code;
				o_timing.code_lo <= 1'b0;
				// Idle bus keeps toggling so stale bytes never look valid
				o_data           <= ~o_data;
			end
		end
	end
endmodule : cpu_timing_model
`default_nettype wire

// [verif/bitmap_video_sync_dma_tb_top.sv]
// Self-checking bench for the video sync, interrupt and DMA controller
`timescale 1ns/10ps
`default_nettype none
module bitmap_video_sync_dma_tb_top
	import video_sync_pkg::*;
();
	localparam int CLK_LIMIT = 97000;
	logic        clock = 1'b0;
	logic        arst_n = 1'b0;
	logic        on_strobe = 1'b0;
	logic        off_strobe = 1'b0;
	logic        bad_code = 1'b0;
	cpu_timing_t timing;
	logic [7:0]  data;
	logic        sync_n, video, dma_n, int_n, flag_n, clear_n;
	logic        flag_prev = 1'b1, int_prev = 1'b1;
	int          error_cnt = 0, checked = 0, clocks = 0;
	int          mc = 0, dma = 0, ints = 0, flags = 0, falls = 0;
	int          loads = 0, pop = 0, vid = 0, int_mc = 0, syncs = 0;
	int          s[8];

	always #12.5 clock = ~clock;

	cpu_timing_model cpu_timing_model_i (
		.i_clock         (clock),
		.i_arst_n        (arst_n),
		.i_bad_code      (bad_code),
		.i_dma_request_n (dma_n),
		.o_timing        (timing),
		.o_data          (data)
	);

	video_sync_dma video_sync_dma_i (
		.i_clock                 (clock),
		.i_arst_n                (arst_n),
		.i_timing_pulse_first    (timing.first),
		.i_timing_pulse_second   (timing.second),
		.i_state_code_hi         (timing.code_hi),
		.i_state_code_lo         (timing.code_lo),
		.i_display_on_strobe     (on_strobe),
		.i_display_off_strobe    (off_strobe),
		.i_data_bus              (data),
		.o_comp_sync_n           (sync_n),
		.o_video                 (video),
		.o_dma_out_request_n     (dma_n),
		.o_interrupt_n           (int_n),
		.o_display_status_flag_n (flag_n),
		.o_clear_n               (clear_n)
	);

	// Running tallies, one sample per machine cycle at the second pulse; clocks and video every clock
	always @(posedge clock) begin
		clocks <= clocks + 1;
		vid    <= vid + int'(video);
		if (timing.second) begin
			mc        <= mc + 1;
			dma       <= dma + int'(!dma_n);
			ints      <= ints + int'(!int_n);
			flags     <= flags + int'(!flag_n);
			syncs     <= syncs + int'(!sync_n);
			falls     <= falls + int'(flag_prev && !flag_n);
			flag_prev <= flag_n;
			int_prev  <= int_n;
			if (int_prev && !int_n) begin
				int_mc <= mc + 1;
			end
		end
		if (timing.second && !timing.code_hi && timing.code_lo) begin
			loads <= loads + 1;
			pop   <= pop + $countones(data);
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done();
		$display("checked=%0d error_cnt=%0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : test_done

	always @(negedge clock) begin
		if (clocks >= CLK_LIMIT) begin
			error_cnt = error_cnt + 1;
			$display("ERROR t=%0t run too long", $time);
			test_done();
		end
	end

	task automatic wait_fall();
		int t;
		t = falls;
		while (falls == t) @(negedge clock);
	endtask : wait_fall

	task automatic take();
		s = '{mc, dma, ints, flags, loads, pop, vid, syncs};
	endtask : take

	task automatic t_reset();
		repeat (16) @(posedge clock);
		@(negedge clock);
		check({sync_n, video, dma_n, int_n, flag_n, clear_n}, 6'h2E);
		@(posedge clock) arst_n <= 1'b1;
		repeat (2) begin
			@(negedge clock);
			check(clear_n, 1'b0);
		end
		@(negedge clock);
		check(clear_n, 1'b1);
		$display("t_reset done");
	endtask : t_reset

	task automatic t_off();
		wait_fall();
		take();
		wait_fall();
		check(mc - s[0], WINDOW_LINES * CYCLES_PER_LINE);
		check(dma - s[1], 32'h0);
		check(ints - s[2], 32'h0);
		check(flags - s[3], FLAG_LINES * CYCLES_PER_LINE);
		check(vid - s[6], 32'h0);
		check(syncs - s[7], WINDOW_LINES);
		$display("t_off done");
	endtask : t_off

	task automatic t_on();
		int w;
		@(posedge clock) on_strobe <= 1'b1;
		@(posedge clock) on_strobe <= 1'b0;
		while (!sync_n) @(negedge clock);
		while (sync_n) @(negedge clock);
		w = 0;
		while (!sync_n) begin
			w = w + 1;
			@(negedge clock);
		end
		check(w >= 9 && w <= 11, 1'b1);
		$display("t_on done");
	endtask : t_on

	task automatic t_field();
		wait_fall();
		take();
		wait_fall();
		check(int_mc - s[0], 2 * CYCLES_PER_LINE);
		wait_fall();
		check(mc - s[0], LINES_PER_FIELD * CYCLES_PER_LINE);
		check(dma - s[1], WINDOW_LINES * BITS_PER_BYTE);
		check(ints - s[2], CYCLES_PER_LINE);
		check(flags - s[3], 2 * FLAG_LINES * CYCLES_PER_LINE);
		check(loads - s[4], WINDOW_LINES * BITS_PER_BYTE);
		check(vid - s[6], pop - s[5]);
		check(syncs - s[7], LINES_PER_FIELD - VSYNC_LINES
			+ VSYNC_LINES * (CYCLES_PER_LINE - 1));
		$display("t_field done");
	endtask : t_field

	task automatic t_skip();
		@(posedge clock) bad_code <= 1'b1;
		off_strobe <= 1'b1;
		@(posedge clock) off_strobe <= 1'b0;
		wait_fall();
		take();
		wait_fall();
		check(mc - s[0], (LINES_PER_FIELD - WINDOW_LINES) * CYCLE_LAST);
		check(flags - s[3], FLAG_LINES * CYCLE_LAST);
		check(dma - s[1], 32'h0);
		check(syncs - s[7], LINES_PER_FIELD - WINDOW_LINES - VSYNC_LINES
			+ VSYNC_LINES * (CYCLES_PER_LINE - 2));
		@(posedge clock) bad_code <= 1'b0;
		$display("t_skip done");
	endtask : t_skip

	initial begin
		t_reset();
		t_off();
		t_on();
		t_field();
		t_skip();
		test_done();
	end
endmodule : bitmap_video_sync_dma_tb_top
`default_nettype wire
